// File: pic_cfg_bridge.sv
// pci initiator configuration access bridge: wishbone slave plus a pci initiator engine
// assumes pic_pkg compiled first; pci pins are sampled, the pci clock edge is detected
//
// Operation
// - direct data read launches config read cycle
// - direct read holds local bus until done
// - no ack within limit raises bus error
// - timeout only when timeout enable is one
// - indirect address and command start pci cycle
// - indirect read result lands in data register
// - completion flag in initiator status register
// - completion interrupt gated by mask register
// - indirect register accesses answer without waiting
// - address phase drives indirect address unchanged
// - command and byte enable fields drive pci
// - read code starts indirect config read
// - write code starts indirect config write
// - status bits clear by writing one
`include "pic_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module pic_cfg_bridge #(
  parameter int unsigned TO_CYCLES = `PIC_TO_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // completion interrupt
  output logic             irq_o,
  // pci initiator pins
  input  wire logic        pci_clk_i,
  input  wire logic [31:0] ad_i,
  input  wire logic        trdy_n_i,
  input  wire logic        stop_n_i,
  input  wire logic        devsel_n_i,
  output logic      [31:0] ad_o,
  output logic             ad_oe_o,
  output logic      [3:0]  cbe_o,
  output logic             cbe_oe_o,
  output logic             frame_n_o,
  output logic             irdy_n_o,
  output logic             ctl_oe_o
);

  // the 10-bit wait counter cannot serve larger limits
  if (TO_CYCLES < 2 || TO_CYCLES > 1024) begin : g_chk
    $error("TO_CYCLES out of range");
  end

  localparam logic [9:0] TO_LAST = 10'(TO_CYCLES - 1);

  // two-flop synchronisers for every pin coming from the pci side
  logic [35:0] s1_r, s2_r;
  logic        clk_d_r;
  wire  [35:0] raw = {pci_clk_i, trdy_n_i, stop_n_i, devsel_n_i, ad_i};

  always_ff @(posedge clk_i) begin
    s1_r    <= raw;
    s2_r    <= s1_r;
    clk_d_r <= s2_r[35];
  end

  // pci rising edge seen in the bus clock domain
  wire        pe       = s2_r[35] & ~clk_d_r;
  wire        trdy_s   = s2_r[34];
  wire        stop_s   = s2_r[33];
  wire        devsel_s = s2_r[32];
  wire [31:0] ad_s     = s2_r[31:0];

  // software registers
  logic [31:0] mask_r, dadr_r, iadr_r, idat_r, icbe_r, chip_configuration_r;
  logic        flag_r, ind_pend_r, dir_pend_r;
  logic [9:0]  to_cnt_r;

  // engine state
  pic_pkg::pic_state_t st_r;
  logic        sel_dir_r, wr_cyc_r;
  logic [2:0]  mab_r;

  // bus decode
  wire req      = cyc_i & stb_i & ~ack_o & ~err_o;
  wire wr       = req & we_i;
  wire hit_stat = adr_i == `PIC_A_STAT;
  wire hit_mask = adr_i == `PIC_A_MASK;
  wire hit_dadr = adr_i == `PIC_A_DADR;
  wire hit_ddat = adr_i == `PIC_A_DDAT;
  wire hit_iadr = adr_i == `PIC_A_IADR;
  wire hit_idat = adr_i == `PIC_A_IDAT;
  wire hit_icbe = adr_i == `PIC_A_ICBE;
  wire hit_chip_configuration = adr_i == `PIC_A_CHIP_CONFIGURATION;
  wire dir_rd   = req & ~we_i & hit_ddat;
  wire plain    = req & ~dir_rd;
  wire [31:0] wm = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nv & m);
  endfunction

  // indirect command decode
  wire [31:0] icbe_new = merge(icbe_r, dat_i, wm);
  wire [3:0]  cmd_new  = icbe_new[`PIC_CMD_LSB +: 4];
  wire        cmd_ok   = (cmd_new == `PIC_CMD_RD) | (cmd_new == `PIC_CMD_WR);
  wire        start    = wr & hit_icbe & cmd_ok & ~ind_pend_r;
  wire [3:0]  ind_cmd  = icbe_r[`PIC_CMD_LSB +: 4];
  wire [3:0]  ind_be   = icbe_r[`PIC_BE_LSB +: 4];
  wire        timeout_enable      = chip_configuration_r[`PIC_TOE_BIT];

  // engine completion decode
  wire mab_out  = devsel_s & (mab_r == `PIC_MABORT);
  wire in_data  = (st_r == pic_pkg::st_data) & pe;
  wire eng_done = in_data & (~trdy_s | mab_out);
  wire eng_rty  = in_data & trdy_s & ~stop_s & ~mab_out;
  wire [31:0] res = trdy_s ? `PIC_ONES32 : ad_s;  // master abort reads all ones
  wire go       = (st_r == pic_pkg::st_idle) & pe & (ind_pend_r | dir_pend_r);
  wire use_dir  = dir_pend_r;  // the waiting local bus goes first

  // completion and timeout events
  wire stat_set = eng_done & ~sel_dir_r;
  wire stat_clr = wr & hit_stat & wm[`PIC_DONE_BIT] & dat_i[`PIC_DONE_BIT];
  wire dir_done = eng_done & sel_dir_r & dir_pend_r;
  wire to_hit   = dir_pend_r & timeout_enable & (to_cnt_r == TO_LAST) & ~dir_done;

  // read data selection
  wire [31:0] rd_mux =
    hit_stat ? {19'h0, flag_r, 12'h0} :
    hit_mask ? mask_r :
    hit_dadr ? dadr_r :
    hit_iadr ? iadr_r :
    hit_idat ? idat_r :
    hit_icbe ? icbe_r :
    hit_chip_configuration ? chip_configuration_r : `PIC_RST32;

  // software-visible registers; engine capture of read data wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= `PIC_RST32;
      dadr_r <= `PIC_RST32;
      iadr_r <= `PIC_RST32;
      idat_r <= `PIC_RST32;
      icbe_r <= `PIC_RST32;
      chip_configuration_r <= `PIC_CHIP_CONFIGURATION_RST;
    end else begin
      if (wr & hit_mask) mask_r <= merge(mask_r, dat_i, wm);
      if (wr & hit_dadr) dadr_r <= merge(dadr_r, dat_i, wm);
      if (wr & hit_iadr) iadr_r <= merge(iadr_r, dat_i, wm);
      if (wr & hit_chip_configuration) chip_configuration_r <= merge(chip_configuration_r, dat_i, wm);
      if (wr & hit_icbe & ~ind_pend_r) icbe_r <= icbe_new;
      if (stat_set & ~wr_cyc_r) idat_r <= res;
      else if (wr & hit_idat) idat_r <= merge(idat_r, dat_i, wm);
    end
  end

  // sticky flag (set wins over clear), pending requests and the wait counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r     <= 1'b0;
      ind_pend_r <= 1'b0;
      dir_pend_r <= 1'b0;
      to_cnt_r   <= 10'h000;
    end else begin
      flag_r     <= stat_set | (flag_r & ~stat_clr);
      ind_pend_r <= start | (ind_pend_r & ~stat_set);
      dir_pend_r <= (dir_rd & ~dir_pend_r) | (dir_pend_r & ~dir_done & ~to_hit);
      to_cnt_r   <= dir_pend_r ? to_cnt_r + 10'h001 : 10'h000;
    end
  end

  // wishbone answer; direct reads are answered only from the pci side or by the timeout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= `PIC_RST32;
      irq_o <= 1'b0;
    end else begin
      ack_o <= plain | dir_done;
      err_o <= to_hit;
      irq_o <= flag_r & mask_r[`PIC_DONE_BIT];
      if (dir_done) dat_o <= res;
      else if (plain & ~we_i) dat_o <= rd_mux;
    end
  end

  // pci initiator engine, single data phase, steps on each detected pci edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= pic_pkg::st_idle;
      sel_dir_r <= 1'b0;
      wr_cyc_r  <= 1'b0;
      mab_r     <= 3'h0;
      ad_o      <= `PIC_RST32;
      ad_oe_o   <= 1'b0;
      cbe_o     <= 4'h0;
      cbe_oe_o  <= 1'b0;
      frame_n_o <= 1'b1;
      irdy_n_o  <= 1'b1;
      ctl_oe_o  <= 1'b0;
    end else if (pe) begin
      unique case (st_r)
        pic_pkg::st_idle: begin
          if (go) begin
            frame_n_o <= 1'b0;
            ctl_oe_o  <= 1'b1;
            ad_o      <= use_dir ? dadr_r : iadr_r;
            ad_oe_o   <= 1'b1;
            cbe_o     <= use_dir ? `PIC_CMD_RD : ind_cmd;
            cbe_oe_o  <= 1'b1;
            sel_dir_r <= use_dir;
            wr_cyc_r  <= ~use_dir & (ind_cmd == `PIC_CMD_WR);
            mab_r     <= 3'h0;
            st_r      <= pic_pkg::st_addr;
          end
        end
        pic_pkg::st_addr: begin
          frame_n_o <= 1'b1;  // one data phase only
          irdy_n_o  <= 1'b0;
          cbe_o     <= sel_dir_r ? 4'h0 : ind_be;
          ad_o      <= idat_r;
          ad_oe_o   <= wr_cyc_r;
          st_r      <= pic_pkg::st_data;
        end
        pic_pkg::st_data: begin
          if (~trdy_s | ~stop_s | mab_out) begin
            // retry also lands here; the still-pending request reissues it
            irdy_n_o <= 1'b1;
            ctl_oe_o <= 1'b0;
            ad_oe_o  <= 1'b0;
            cbe_oe_o <= 1'b0;
            st_r     <= pic_pkg::st_idle;
          end else if (devsel_s) begin
            mab_r <= mab_r + 3'h1;
          end
        end
        default: st_r <= pic_pkg::st_idle;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_dir_issue;
    dir_rd & ~dir_pend_r;
  endsequence

  property p_dir_launch;
    s_dir_issue |=> dir_pend_r;
  endproperty
  a_dir_launch: assert property (p_dir_launch) else $error("direct read not launched");

  property p_dir_hold;
    dir_pend_r & ~dir_done |=> ~ack_o;
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direct read acked early");

  property p_to_err;
    dir_pend_r & timeout_enable & (to_cnt_r == TO_LAST) & ~dir_done |=> err_o & ~dir_pend_r;
  endproperty
  a_to_err: assert property (p_to_err) else $error("timeout did not raise error");

  property p_no_err;
    ~timeout_enable |=> ~err_o;
  endproperty
  a_no_err: assert property (p_no_err) else $error("error with timeout disabled");

  property p_ind_start;
    start |=> ind_pend_r ##[1:40] (st_r == pic_pkg::st_addr);
  endproperty
  a_ind_start: assert property (p_ind_start) else $error("indirect access not started");

  property p_ind_data;
    stat_set & ~wr_cyc_r |=> idat_r == $past(res);
  endproperty
  a_ind_data: assert property (p_ind_data) else $error("read data not captured");

  property p_flag;
    stat_set |=> flag_r;
  endproperty
  a_flag: assert property (p_flag) else $error("completion flag not set");

  property p_sticky;
    flag_r & ~stat_clr |=> flag_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_irq;
    flag_r & mask_r[`PIC_DONE_BIT] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_ind_ack;
    plain |=> ack_o;
  endproperty
  a_ind_ack: assert property (p_ind_ack) else $error("register access not acked");

  property p_addr_phase;
    (st_r == pic_pkg::st_addr) & ~sel_dir_r |-> ad_o == iadr_r && cbe_o == ind_cmd && ad_oe_o;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong");

  property p_retry;
    eng_rty & sel_dir_r & dir_pend_r & ~to_hit |=> dir_pend_r && st_r == pic_pkg::st_idle;
  endproperty
  a_retry: assert property (p_retry) else $error("retried read abandoned");

  property p_clear;
    stat_clr & ~stat_set |=> ~flag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear");

  // a direct request always carries the read code and a live frame in its address phase
  property p_dir_cmd;
    (st_r == pic_pkg::st_addr) & sel_dir_r |-> cbe_o == `PIC_CMD_RD && !frame_n_o;
  endproperty
  a_dir_cmd: assert property (p_dir_cmd) else $error("direct command wrong");

  // with nothing pending and no command written the engine must stay idle
  property p_no_start;
    (st_r == pic_pkg::st_idle) & ~ind_pend_r & ~dir_pend_r & ~start
      |=> st_r == pic_pkg::st_idle;
  endproperty
  a_no_start: assert property (p_no_start) else $error("access started without command");

  // the bus error is one pulse; the held request must not raise it again
  property p_err_pulse;
    err_o |=> ~err_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("bus error repeated");

endmodule

`default_nettype wire

// File: pic_defines.svh
// constants for the pci configuration access bridge: offsets, fields, resets, counts
// assumes inclusion by bare name from the bridge module and the bench
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH
// register byte addresses on the wishbone bus
`define PIC_A_STAT   32'hFFFED044
`define PIC_A_MASK   32'hFFFED048
`define PIC_A_DADR   32'hFFFED138
`define PIC_A_DDAT   32'hFFFED13C
`define PIC_A_IADR   32'hFFFED150
`define PIC_A_IDAT   32'hFFFED154
`define PIC_A_ICBE   32'hFFFED158
`define PIC_A_CHIP_CONFIGURATION   32'hFFFED040
// field positions
`define PIC_DONE_BIT 12
`define PIC_TOE_BIT  0
`define PIC_CMD_LSB  4
`define PIC_BE_LSB   0
// command codes in the indirect command field
`define PIC_CMD_RD   4'hA
`define PIC_CMD_WR   4'hB
// reset values
`define PIC_RST32    32'h0000_0000
`define PIC_CHIP_CONFIGURATION_RST 32'h0000_0001
`define PIC_ONES32   32'hFFFF_FFFF
// local bus wait limit in bus clock cycles
`define PIC_TO_CYCLES 512
// pci clocks without devsel before a master abort
`define PIC_MABORT   3'h5
`endif

// File: pic_pkg.sv
// types shared by the pci configuration access bridge
// assumes nothing beyond a systemverilog compiler
package pic_pkg;
  // pci initiator engine states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_addr = 2'b01,
    st_data = 2'b10
  } pic_state_t;
endpackage

// File: pic_tgt.sv
// pci target model answering configuration cycles of the bridge
// assumes the bench resolves the ad lines from the bridge's ad enable alone
`timescale 1ns/10ps
`default_nettype none
module pic_tgt (
  // pci pins
  input  wire logic        pclk_i,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_i,
  output logic             devsel_n_o,
  output logic             trdy_n_o,
  output logic             stop_n_o,
  output logic      [31:0] ad_o,
  // scenario control
  input  wire logic [31:0] rdat_i,
  input  wire logic [1:0]  retry_i,
  input  wire logic        slow_i,
  input  wire logic        nodev_i,
  // what the target saw
  output logic      [31:0] adr_o,
  output logic      [31:0] wdat_o,
  output logic      [3:0]  cmd_o,
  output logic      [3:0]  be_o,
  output int               ncyc_o
);
  logic act = 0;
  logic seen = 0;
  int   nret = 0;
  initial begin
    {devsel_n_o, trdy_n_o, stop_n_o} = 3'h7;
    ad_o = '0;
    ncyc_o = 0;
  end
  // controls hold until the initiator ends the data phase, so a slow sampler never misses them
  always @(posedge pclk_i) begin
    ad_o <= ~ad_o; // released lines toggle so stale data never matches
    if (!act && !frame_n_i && !nodev_i) begin
      act <= 1'b1;
      seen <= 1'b0;
      adr_o <= ad_i;
      cmd_o <= cbe_i;
      ncyc_o <= ncyc_o + 1;
      devsel_n_o <= 1'b0;
    end else if (act && !irdy_n_i) begin
      seen <= 1'b1;
      be_o <= cbe_i;
      if (!slow_i || seen) begin
        if (nret < retry_i) stop_n_o <= 1'b0;
        else begin
          trdy_n_o <= 1'b0;
          wdat_o <= ad_i;
          if (cmd_o == 4'hA) ad_o <= rdat_i;
        end
      end
    end else if (act && seen) begin
      {devsel_n_o, trdy_n_o, stop_n_o} <= 3'h7;
      act <= 1'b0;
      nret <= stop_n_o ? 0 : nret + 1;
    end
  end
endmodule
`default_nettype wire

// File: test_pic_cfg_bridge.sv
// bench for the configuration access bridge against the pci target model
// assumes pic_defines.svh on the include path and pic_tgt compiled first
`include "pic_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module test_pic_cfg_bridge;
  logic        clk_i = 0, rst_i = 1, pclk = 0, we = 0, cyc = 0, stb = 0;
  logic        nodev = 0, slow = 0, ack, err, irq, adoe, cbeoe, frn, irn, ctloe, dvn, trn, stn, e;
  logic [31:0] adr = '0, dat = '0, rdat = '0, q, ado, tad, adw, tadr, twd, r;
  logic [3:0]  cbe, tcmd, tbe;
  logic [1:0]  retry = '0;
  int          failures = 0, tests_run = 0, lat, ncyc, n0;
  initial forever #10 clk_i = ~clk_i;
  // pci clock offset from the bus clock
  initial begin
    #37;
    forever #80 pclk = ~pclk;
  end
  assign adw = adoe ? ado : tad;
  pic_cfg_bridge #(.TO_CYCLES(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat),
    .sel_i(4'hF), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(q), .ack_o(ack), .err_o(err),
    .irq_o(irq), .pci_clk_i(pclk), .ad_i(adw), .trdy_n_i(trn), .stop_n_i(stn),
    .devsel_n_i(dvn), .ad_o(ado), .ad_oe_o(adoe), .cbe_o(cbe), .cbe_oe_o(cbeoe),
    .frame_n_o(frn), .irdy_n_o(irn), .ctl_oe_o(ctloe));
  pic_tgt tgt (.pclk_i(pclk), .frame_n_i(ctloe ? frn : 1'b1), .irdy_n_i(ctloe ? irn : 1'b1),
    .ad_i(adw), .cbe_i(cbeoe ? cbe : 4'hF), .devsel_n_o(dvn), .trdy_n_o(trn), .stop_n_o(stn),
    .ad_o(tad),
    .rdat_i(rdat), .retry_i(retry), .slow_i(slow), .nodev_i(nodev), .adr_o(tadr),
    .wdat_o(twd), .cmd_o(tcmd), .be_o(tbe), .ncyc_o(ncyc));
  task automatic chk(input string n, input logic [31:0] x, g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask
  // one classic cycle; only the answer ends it
  task automatic wb(input logic w, input logic [31:0] a, d);
    lat = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      lat++;
    end while (ack !== 1'b1 && err !== 1'b1);
    r = q;
    e = err;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic poll();
    for (int i = 0; i < 80; i++) begin
      wb(0, `PIC_A_STAT, '0);
      if (r[`PIC_DONE_BIT] === 1'b1) break;
    end
  endtask
  task automatic t_reset();
    wb(0, `PIC_A_CHIP_CONFIGURATION, '0); chk("chip_configuration", `PIC_CHIP_CONFIGURATION_RST, r);
    wb(0, `PIC_A_STAT, '0); chk("status", '0, r);
    wb(1, 32'hFFFED0FC, `PIC_ONES32);
    wb(0, 32'hFFFED0FC, '0); chk("unmapped", '0, r);
  endtask
  task automatic t_ind_rd();
    rdat <= 32'h5A3C_0F96;
    retry <= 1;
    slow <= 1;
    n0 = ncyc;
    wb(1, `PIC_A_MASK, 32'h0000_1000);
    wb(1, `PIC_A_IADR, 32'h0000_4108); chk("adr lat", 2, lat);
    wb(1, `PIC_A_ICBE, 32'h0000_00A6); chk("cmd lat", 2, lat);
    poll(); chk("done", 32'h0000_1000, r);
    chk("irq", 1, {31'h0, irq});
    chk("addr phase", 32'h0000_4108, tadr);
    chk("command", 4'hA, tcmd);
    chk("byte en", 4'h6, tbe);
    wb(0, `PIC_A_IDAT, '0); chk("rd data", 32'h5A3C_0F96, r);
    wb(0, `PIC_A_STAT, '0); chk("sticky", 32'h0000_1000, r);
    wb(1, `PIC_A_STAT, 32'h0000_1000);
    wb(0, `PIC_A_STAT, '0); chk("cleared", '0, r);
    chk("irq off", 0, {31'h0, irq});
    chk("cycles", n0 + 2, ncyc);
  endtask
  task automatic t_ind_wr();
    retry <= 0;
    slow <= 0;
    wb(1, `PIC_A_IDAT, 32'hC3A5_1E78);
    wb(1, `PIC_A_IADR, 32'h0010_0204);
    wb(1, `PIC_A_ICBE, 32'h0000_00B3);
    poll(); chk("wr done", 32'h0000_1000, r);
    chk("wr data", 32'hC3A5_1E78, twd);
    chk("wr cmd", 4'hB, tcmd);
    chk("wr be", 4'h3, tbe);
    wb(1, `PIC_A_STAT, 32'h0000_1000);
    // an unknown command code is stored but must start nothing
    n0 = ncyc;
    wb(1, `PIC_A_ICBE, 32'h0000_0026);
    repeat (40) @(posedge clk_i);
    chk("no start", n0, ncyc);
    wb(0, `PIC_A_ICBE, '0); chk("cmd kept", 32'h0000_0026, r);
  endtask
  task automatic t_direct();
    nodev <= 1;
    wb(0, `PIC_A_DDAT, '0); chk("timeout", 1, {31'h0, e});
    chk("to lat", 32'h12, lat);
    for (int i = 0; i < 60 && ctloe !== 1'b1; i++) @(posedge clk_i);
    for (int i = 0; i < 200 && ctloe !== 1'b0; i++) @(posedge clk_i);
    chk("abort end", 32'h0, {31'h0, ctloe});
    wb(1, `PIC_A_CHIP_CONFIGURATION, '0);
    wb(0, `PIC_A_DDAT, '0); chk("no err", 0, {31'h0, e});
    chk("abort", `PIC_ONES32, r);
    nodev <= 0;
    retry <= 1;
    slow <= 1;
    n0 = ncyc;
    wb(1, `PIC_A_DADR, 32'h0002_0310);
    wb(0, `PIC_A_DDAT, '0); chk("direct", 32'h5A3C_0F96, r);
    chk("held", 1, {31'h0, lat > 20});
    chk("dir addr", 32'h0002_0310, tadr);
    chk("dir cmd", 4'hA, tcmd);
    chk("reissue", n0 + 2, ncyc);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog standing in for a system reset on a stuck bus
  initial begin
    #300000;
    $display("FAIL watchdog expected finish seen timeout");
    failures++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_ind_rd();
    t_ind_wr();
    t_direct();
    close_out();
  end
endmodule
`default_nettype wire
